// ===== core/pc_load_logic.sv
// Implementation choices: the address map and register access over APB.
`default_nettype none
// program counter with apb view of low byte and high latch
module pc_load_logic
	import pc_load_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic exec_valid_i,
	input wire pc_load_pkg::pc_op_t exec_op_i,
	input wire logic [7:0] acc_i,
	input wire logic [pc_load_pkg::CALL_OP_W-1:0] operand_i,
	output logic [pc_load_pkg::PC_W-1:0] pc_o
);
	import pc_load_pkg::*;

	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic [LATCH_W-1:0] latch_ff, nxt_latch;
	logic [31:0] rdata_ff, nxt_rdata;
	logic err_ff, nxt_err;
	logic wr_acc, rd_acc;
	pc_target_if t ();

	function automatic logic known_addr(input logic [11:0] a);
		known_addr = (a == ADDR_PC_LOW) || (a == ADDR_LATCH) || (a == ADDR_PC_FULL);
	endfunction

	// zero-wait apb: answer in the access cycle itself
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign rd_acc = psel_i && !penable_i && !pwrite_i;
	assign pready_o = 1'b1;
	assign prdata_o = rdata_ff;
	assign pslverr_o = err_ff;
	assign pc_o = pc_ff;

	// request to the target calculator; apb low-byte write wins over execute
	always_comb begin
		t.pc = pc_ff;
		t.latch = latch_ff;
		t.operand = operand_i;
		t.acc = acc_i;
		t.op = exec_valid_i ? exec_op_i : OP_NONE;
		if (wr_acc && paddr_i == ADDR_PC_LOW) begin
			t.op = OP_WRITE_LOW;
			t.acc = pwdata_i[7:0];
		end
	end

	pc_target_calc u_calc (
		.t(t)
	);

	// next state of counter, latch and read data
	always_comb begin
		nxt_pc = t.load ? t.target : pc_ff;
		nxt_latch = latch_ff;
		nxt_rdata = rdata_ff;
		nxt_err = 1'b0;
		if (wr_acc && paddr_i == ADDR_LATCH) begin
			nxt_latch = pwdata_i[LATCH_W-1:0];
		end
		// full-pc writes change nothing; upper pc bits stay hidden
		if (wr_acc && paddr_i == ADDR_PC_FULL) begin
			nxt_err = 1'b0;
		end
		// sample read data in setup so it is valid in access
		if (rd_acc) begin
			case (paddr_i)
				ADDR_PC_LOW: nxt_rdata = {24'h000000, pc_ff[7:0]};
				ADDR_LATCH: nxt_rdata = {25'h0000000, latch_ff};
				ADDR_PC_FULL: nxt_rdata = 32'h00000000;
				default: nxt_rdata = 32'h00000000;
			endcase
		end
		if (psel_i && !penable_i) begin
			nxt_err = !known_addr(paddr_i);
		end
	end

	// registers; reset clears the counter
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pc_ff <= PC_RST;
			latch_ff <= LATCH_RST;
			rdata_ff <= 32'h00000000;
			err_ff <= 1'b0;
		end else begin
			pc_ff <= nxt_pc;
			latch_ff <= nxt_latch;
			rdata_ff <= nxt_rdata;
			err_ff <= nxt_err;
		end
	end

	// sequential step lands one edge after the fetch
	a_step_inc: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_STEP && !wr_acc
		|=> pc_ff == PC_W'($past(pc_ff) + 15'h0001)
	) else $error("step did not increment");

	// top of program memory rolls over to zero, no sixteenth bit
	a_step_wrap: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_STEP && !wr_acc && pc_ff == 15'h7fff
		|=> pc_ff == 15'h0000
	) else $error("step did not wrap");

	// a no-op slot must not move the counter
	a_none_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_NONE && !wr_acc
		|=> $stable(pc_ff)
	) else $error("pc moved on empty slot");

	// software low-byte write pulls the upper bits from the latch
	a_low_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && paddr_i == ADDR_PC_LOW
		|=> pc_ff == {$past(latch_ff), $past(pwdata_i[7:0])}
	) else $error("low write mismatch");

	// bus write wins over a concurrent execute op
	a_apb_over_exec: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && paddr_i == ADDR_PC_LOW && exec_valid_i
		|=> pc_ff[7:0] == $past(pwdata_i[7:0])
	) else $error("execute op beat bus write");

	// instruction result written to the low byte
	a_exec_low: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_WRITE_LOW && !wr_acc
		|=> pc_ff == {$past(latch_ff), $past(acc_i)}
	) else $error("result write mismatch");

	// computed jump: low byte wraps, never carries upward
	a_add_low: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_ADD_LOW && !wr_acc
		|=> pc_ff[14:8] == $past(latch_ff)
		&& pc_ff[7:0] == 8'($past(pc_ff[7:0]) + $past(acc_i))
	) else $error("computed jump mismatch");

	// absolute call mixes operand and latch bits
	a_call_abs: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_CALL_ABS && !wr_acc
		|=> pc_ff == {$past(latch_ff[6:3]), $past(operand_i)}
	) else $error("absolute call mismatch");

	// computed call through the accumulator
	a_call_acc: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_CALL_ACC && !wr_acc
		|=> pc_ff == {$past(latch_ff), $past(acc_i)}
	) else $error("accumulator call mismatch");

	// unsigned accumulator offset over the full width
	a_branch_acc: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_BRANCH_ACC && !wr_acc
		|=> pc_ff == PC_W'($past(pc_ff) + 15'h0001 + {7'h00, $past(acc_i)})
	) else $error("accumulator branch mismatch");

	// signed operand offset, may go backwards across blocks
	a_branch_imm: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_BRANCH_IMM && !wr_acc
		|=> pc_ff == PC_W'($past(pc_ff) + 15'h0001
		+ {{6{$past(operand_i[8])}}, $past(operand_i[8:0])})
	) else $error("immediate branch mismatch");

	// with no load source the counter holds
	a_hold_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!exec_valid_i && !wr_acc
		|=> $stable(pc_ff)
	) else $error("pc moved while idle");

	// first edge after any reset still sees zero
	a_reset_clear: assert property (
		@(posedge clk_i)
		$fell(rst_i)
		|-> pc_ff == PC_RST
	) else $error("pc not cleared by reset");

	// low byte read data captured in setup, shown in access
	a_read_low: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd_acc && paddr_i == ADDR_PC_LOW
		|=> prdata_o == {24'h000000, $past(pc_ff[7:0])}
	) else $error("low byte read mismatch");

	// latch reads back, upper pc bits never do
	a_read_latch: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd_acc && paddr_i == ADDR_LATCH
		|=> prdata_o == {25'h0000000, $past(latch_ff)}
	) else $error("latch read mismatch");

	// full-pc word hides the upper bits
	a_read_full: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd_acc && paddr_i == ADDR_PC_FULL
		|=> prdata_o == 32'h00000000
	) else $error("hidden bits leaked on read");

	// unmapped reads return zero
	a_read_unmapped: assert property (
		@(posedge clk_i) disable iff (rst_i)
		rd_acc && !known_addr(paddr_i)
		|=> prdata_o == 32'h00000000
	) else $error("unmapped read not zero");

	// read data stands until the next read setup
	a_rdata_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!rd_acc
		|=> $stable(prdata_o)
	) else $error("read data moved");

	// error flag raised for an unmapped address
	a_err_unmapped: assert property (
		@(posedge clk_i) disable iff (rst_i)
		psel_i && !penable_i && !known_addr(paddr_i)
		|=> pslverr_o
	) else $error("unmapped access not flagged");

	// mapped addresses never flag an error
	a_err_mapped: assert property (
		@(posedge clk_i) disable iff (rst_i)
		psel_i && !penable_i && known_addr(paddr_i)
		|=> !pslverr_o
	) else $error("mapped access flagged");

	// error flag quiet while the bus is idle
	a_err_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!psel_i
		|=> !pslverr_o
	) else $error("error flag while idle");

	// error flag lasts only the access cycle
	a_err_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		psel_i && penable_i
		|=> !pslverr_o
	) else $error("error flag outlived access");

	// latch takes the written seven bits
	a_latch_write: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && paddr_i == ADDR_LATCH
		|=> latch_ff == $past(pwdata_i[LATCH_W-1:0])
	) else $error("latch write mismatch");

	// latch only changes through its own address
	a_latch_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!(wr_acc && paddr_i == ADDR_LATCH)
		|=> $stable(latch_ff)
	) else $error("latch moved without write");

	// writes to the full-pc word are dropped
	a_full_ignored: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_acc && paddr_i == ADDR_PC_FULL && !exec_valid_i
		|=> $stable(pc_ff) && $stable(latch_ff)
	) else $error("full-pc write took effect");

	// a bus read has no side effect on the counter
	a_read_still: assert property (
		@(posedge clk_i) disable iff (rst_i)
		psel_i && !pwrite_i && !exec_valid_i
		|=> $stable(pc_ff)
	) else $error("read moved the pc");

	// every real op asks the calculator for a load
	a_calc_load: assert property (
		@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i != OP_NONE
		|-> t.load
	) else $error("op without load");

	// no load request without a source
	a_calc_idle: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!exec_valid_i && !wr_acc
		|-> !t.load
	) else $error("load without source");

	// main scenarios worth seeing at least once
	c_low_write: cover property (@(posedge clk_i) wr_acc && paddr_i == ADDR_PC_LOW);
	c_branch_back: cover property (@(posedge clk_i)
		exec_valid_i && exec_op_i == OP_BRANCH_IMM && operand_i[8]);
	c_call_acc: cover property (@(posedge clk_i) exec_valid_i && exec_op_i == OP_CALL_ACC);
	c_branch_cross: cover property (@(posedge clk_i) disable iff (rst_i)
		exec_valid_i && exec_op_i == OP_BRANCH_ACC && !wr_acc
		##1 pc_ff[14:8] != $past(pc_ff[14:8]));
	c_write_over_exec: cover property (@(posedge clk_i)
		wr_acc && paddr_i == ADDR_PC_LOW && exec_valid_i);
endmodule
`default_nettype wire

// ===== core/pc_load_pkg.sv
// How it works
// - program counter is fifteen bits wide
// - low byte readable and writable by software
// - upper bits loaded from high latch, except step and branch carries and bits 10:8 of absolute call
// - any reset clears the whole counter
// - low byte write also loads upper bits
// - computed jump adds offset to low byte
// - absolute call mixes operand and latch bits
// - accumulator call uses accumulator and latch
// - accumulator branch adds unsigned accumulator to next
// - immediate branch adds sign-extended operand to next
// - relative branches span the full width
`default_nettype none
package pc_load_pkg;
	localparam int PC_W = 15;
	localparam int LATCH_W = 7;
	localparam int CALL_OP_W = 11;
	localparam int BRA_OP_W = 9;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
	// register byte addresses on apb
	localparam logic [11:0] ADDR_PC_LOW = 12'h000;
	localparam logic [11:0] ADDR_LATCH = 12'h004;
	localparam logic [11:0] ADDR_PC_FULL = 12'h008;
	// operation select from the execute path
	typedef enum logic [2:0] {
		OP_NONE,
		OP_STEP,
		OP_WRITE_LOW,
		OP_ADD_LOW,
		OP_CALL_ABS,
		OP_CALL_ACC,
		OP_BRANCH_ACC,
		OP_BRANCH_IMM
	} pc_op_t;
endpackage
`default_nettype wire

// ===== core/pc_target_if.sv
`default_nettype none
// carries one pc computation request and its result
interface pc_target_if;
	import pc_load_pkg::*;
	pc_op_t op;
	logic [PC_W-1:0] pc;
	logic [LATCH_W-1:0] latch;
	logic [7:0] acc;
	logic [CALL_OP_W-1:0] operand;
	logic [PC_W-1:0] target;
	logic load;
	modport req (output op, pc, latch, acc, operand, input target, load);
	modport calc (input op, pc, latch, acc, operand, output target, load);
endinterface
`default_nettype wire

// ===== core/pc_target_calc.sv
`default_nettype none
module pc_target_calc
	import pc_load_pkg::*;
(
	pc_target_if.calc t
);
	logic [PC_W-1:0] next_seq;
	logic [PC_W-1:0] imm_ext;
	// next sequential address, wraps in fifteen bits
	assign next_seq = PC_W'(t.pc + 15'h0001);
	assign imm_ext = {{(PC_W-BRA_OP_W){t.operand[BRA_OP_W-1]}}, t.operand[BRA_OP_W-1:0]};
	// target selection per operation
	always_comb begin
		t.target = t.pc;
		t.load = 1'b1;
		case (t.op)
			OP_STEP: t.target = next_seq;
			// result byte arrives in acc; upper from latch only
			OP_WRITE_LOW: t.target = {t.latch, t.acc};
			// low byte alone; no carry into upper bits
			OP_ADD_LOW: t.target = {t.latch, 8'(t.pc[7:0] + t.acc)};
			OP_CALL_ABS: t.target = {t.latch[6:3], t.operand[10:0]};
			OP_CALL_ACC: t.target = {t.latch, t.acc};
			OP_BRANCH_ACC: t.target = PC_W'(next_seq + {7'h00, t.acc});
			OP_BRANCH_IMM: t.target = PC_W'(next_seq + imm_ext);
			default: t.load = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ===== verification/tb.sv
`default_nettype none
module tb
	import pc_load_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic exec_valid_i = 1'b0, pready_o, pslverr_o, er;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	pc_op_t exec_op_i = OP_NONE;
	logic [7:0] acc_i = 8'h00;
	logic [CALL_OP_W-1:0] operand_i = 11'h000;
	logic [PC_W-1:0] pc_o;
	int err_count = 0, compares = 0;
	// free running core clock, 8 ns
	always #4 clk_i = ~clk_i;
	pc_load_logic i_pc_load_logic (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.exec_valid_i(exec_valid_i), .exec_op_i(exec_op_i), .acc_i(acc_i),
		.operand_i(operand_i), .pc_o(pc_o));
	task give_verdict;
		if (err_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	task chk_pc(input logic [PC_W-1:0] exp);
		compares++;
		if (pc_o !== exp) begin
			err_count++;
			$display("MISMATCH %0t pc got %h exp %h", $time, pc_o, exp);
		end
	endtask
	// apb transfer; request held until pready is seen high at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// one executed op, result visible after the next edge
	task ex(input pc_op_t op, input logic [7:0] a, input logic [CALL_OP_W-1:0] o);
		@(posedge clk_i);
		exec_valid_i <= 1'b1;
		exec_op_i <= op;
		acc_i <= a;
		operand_i <= o;
		@(posedge clk_i);
		exec_valid_i <= 1'b0;
		#1;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk_pc(15'h0000);
		chk_reg({31'h0, pready_o}, 32'h1);
		apb(1'b0, ADDR_PC_LOW, 32'h0);
		chk_reg(rd, 32'h0);
		chk_reg({31'h0, er}, 32'h0);
		apb(1'b1, ADDR_LATCH, 32'hffff_ffd5);
		apb(1'b0, ADDR_LATCH, 32'h0);
		chk_reg(rd, 32'h55);
		apb(1'b1, ADDR_PC_LOW, 32'h0000_01a3);
		@(posedge clk_i);
		#1 chk_pc(15'h55a3);
		apb(1'b0, ADDR_PC_LOW, 32'h0);
		chk_reg(rd, 32'ha3);
		apb(1'b1, ADDR_PC_FULL, 32'h7fff);
		apb(1'b0, ADDR_PC_FULL, 32'h0);
		chk_reg(rd, 32'h0);
		#1 chk_pc(15'h55a3);
		apb(1'b0, 12'h00c, 32'h0);
		chk_reg({31'h0, er}, 32'h1);
		ex(OP_STEP, 8'h00, 11'h000);
		chk_pc(15'h55a4);
		ex(OP_NONE, 8'hff, 11'h7ff);
		chk_pc(15'h55a4);
		ex(OP_ADD_LOW, 8'h70, 11'h000);
		chk_pc(15'h5514);
		ex(OP_CALL_ABS, 8'h00, 11'h7ff);
		chk_pc(15'h57ff);
		ex(OP_CALL_ACC, 8'h3c, 11'h000);
		chk_pc(15'h553c);
		ex(OP_BRANCH_ACC, 8'hf0, 11'h000);
		chk_pc(15'h562d);
		ex(OP_BRANCH_IMM, 8'h00, 11'h700);
		chk_pc(15'h552e);
		ex(OP_WRITE_LOW, 8'h81, 11'h000);
		chk_pc(15'h5581);
		apb(1'b1, ADDR_LATCH, 32'h7f);
		apb(1'b1, ADDR_PC_LOW, 32'hff);
		@(posedge clk_i);
		#1 chk_pc(15'h7fff);
		ex(OP_STEP, 8'h00, 11'h000);
		chk_pc(15'h0000);
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		#1 chk_pc(15'h0000);
		@(posedge clk_i);
		rst_i <= 1'b0;
		apb(1'b0, ADDR_LATCH, 32'h0);
		chk_reg(rd, 32'h0);
		give_verdict;
	end
	// hang guard, far beyond the roughly sixty cycles of the tests
	initial begin
		repeat (3000) @(posedge clk_i);
		err_count++;
		give_verdict;
	end
endmodule
`default_nettype wire
